// ===== src/dac_update_pkg.sv
// Register map, field layout and trigger source codes of the converter update control
package dac_update_pkg;
    localparam int ADDR_W = 2;
    localparam logic [1:0] OFS_CONTROL    = 2'h0;
    localparam logic [1:0] OFS_VALUE_LOW  = 2'h1;
    localparam logic [1:0] OFS_VALUE_HIGH = 2'h2;
    localparam int POS_CONVERTER_ENABLE   = 0;
    localparam int POS_OUTPUT_PIN_ENABLE  = 1;
    localparam int POS_LEFT_ADJUST        = 2;
    localparam int POS_TRIGGER_SELECT_LO  = 4;
    localparam int POS_AUTO_TRIGGER       = 7;
    localparam logic [7:0] CONTROL_WMASK  = 8'hF7;
    localparam logic [7:0] RESET_CONTROL  = 8'h00;
    localparam logic [7:0] RESET_VALUE    = 8'h00;
    localparam logic [9:0] RESET_SHADOW   = 10'h000;
    localparam int NUM_SOURCES = 8;
    localparam int CONV_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        SRC_COMPARATOR0   = 3'h0,
        SRC_COMPARATOR1   = 3'h1,
        SRC_EXT_INT0      = 3'h2,
        SRC_TIMER0_CMP    = 3'h3,
        SRC_TIMER0_OVF    = 3'h4,
        SRC_TIMER1_CMP_B  = 3'h5,
        SRC_TIMER1_OVF    = 3'h6,
        SRC_TIMER1_CAPT   = 3'h7
    } trigger_source_type;
endpackage

// ===== src/dac_input_update_control.sv
// Control, input and shadow value registers of the 10-bit converter
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module dac_input_update_control
    import dac_update_pkg::*;
#(
    parameter int CONV_COUNT = CONV_CYCLES
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic [dac_update_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_write,
    input  wire logic                          reg_read,
    output logic      [7:0]                    reg_rdata,
    input  wire logic [dac_update_pkg::NUM_SOURCES-1:0] event_flags,
    output logic      [9:0]                    converter_value,
    output logic                               converter_enable,
    output logic                               analog_output_pin,
    output logic                               internal_use,
    output logic                               conversion_busy
);
    import dac_update_pkg::*;

    localparam int CNT_W = $clog2(CONV_COUNT + 1);

    typedef struct packed {
        logic [7:0]                 control;
        logic [7:0]                 value_high;
        logic [7:0]                 value_low;
        logic [9:0]                 shadow;
        logic                       low_pending;
        logic                       armed;
        logic                       align;
        logic [NUM_SOURCES-1:0]     sync1;
        logic [NUM_SOURCES-1:0]     sync2;
        logic                       trig_prev;
        logic [CNT_W-1:0]           conv_cnt;
        logic [7:0]                 rdata;
    } state_type;

    state_type state_ff;
    state_type nxt_state;

    // Assemble the 10-bit value from both input registers under the given alignment
    function automatic logic [9:0] assemble(input logic left, input logic [7:0] hi,
                                            input logic [7:0] lo);
        assemble = left ? {hi, lo[7:6]} : {hi[1:0], lo};
    endfunction

    logic       wr_ctrl;
    logic       wr_low;
    logic       wr_high;
    logic       auto_mode;
    logic       trig_level;
    logic       trig_rise;
    logic       busy;
    logic [2:0] sel;

    always_comb begin
        wr_ctrl    = reg_write && reg_addr == OFS_CONTROL;
        wr_low     = reg_write && reg_addr == OFS_VALUE_LOW;
        wr_high    = reg_write && reg_addr == OFS_VALUE_HIGH;
        auto_mode  = state_ff.control[POS_AUTO_TRIGGER];
        sel        = state_ff.control[POS_TRIGGER_SELECT_LO +: 3];
        // Selected flag after both sync stages, gated by auto-trigger, independent of any interrupt enable
        trig_level = auto_mode && state_ff.sync2[sel];
        busy       = state_ff.conv_cnt != '0;
        trig_rise  = trig_level && !state_ff.trig_prev;

        nxt_state           = state_ff;
        nxt_state.sync1     = event_flags;
        nxt_state.sync2     = state_ff.sync1;
        nxt_state.trig_prev = trig_level;
        if (busy) begin
            nxt_state.conv_cnt = state_ff.conv_cnt - CNT_W'(1);
        end

        if (wr_ctrl) begin
            nxt_state.control = reg_wdata & CONTROL_WMASK;
        end
        if (wr_low) begin
            nxt_state.value_low   = reg_wdata;
            nxt_state.low_pending = 1'b1;
            nxt_state.armed       = 1'b0;
        end
        if (wr_high) begin
            nxt_state.value_high  = reg_wdata;
            nxt_state.low_pending = 1'b0;
            // Alignment used by later trigger updates is the one in force at this write
            nxt_state.align       = state_ff.control[POS_LEFT_ADJUST];
            if (!auto_mode) begin
                // Alignment is sampled here, so a later change waits for the next high write
                nxt_state.shadow = assemble(state_ff.control[POS_LEFT_ADJUST],
                                            reg_wdata, state_ff.value_low);
            end else begin
                nxt_state.armed = 1'b1;
            end
        end

        // Trigger rises are dropped while a conversion is running
        if (auto_mode && trig_rise && !busy) begin
            if (state_ff.armed && !state_ff.low_pending) begin
                nxt_state.shadow = assemble(state_ff.align,
                                            state_ff.value_high, state_ff.value_low);
            end
            nxt_state.conv_cnt = CNT_W'(CONV_COUNT);
        end

        nxt_state.rdata = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                OFS_CONTROL:    nxt_state.rdata = state_ff.control;
                OFS_VALUE_LOW:  nxt_state.rdata = state_ff.value_low;
                OFS_VALUE_HIGH: nxt_state.rdata = state_ff.value_high;
                default:        nxt_state.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff             <= '0;
            state_ff.control     <= RESET_CONTROL;
            state_ff.value_high  <= RESET_VALUE;
            state_ff.value_low   <= RESET_VALUE;
            state_ff.shadow      <= RESET_SHADOW;
            state_ff.low_pending <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Shadow is never on the register bus, only on the converter side
    always_comb begin
        reg_rdata         = state_ff.rdata;
        converter_enable  = state_ff.control[POS_CONVERTER_ENABLE];
        converter_value   = converter_enable ? state_ff.shadow : 10'h000;
        analog_output_pin = converter_enable && state_ff.control[POS_OUTPUT_PIN_ENABLE];
        internal_use      = converter_enable && !state_ff.control[POS_OUTPUT_PIN_ENABLE];
        conversion_busy   = busy;
    end
endmodule

// ===== test/dac_update_chk.sv
// Port-level assertion checker for the converter update control
`timescale 1ns/1ps
module dac_update_chk #(parameter int CONV_COUNT = 4) (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [9:0] converter_value,
    input wire logic       converter_enable,
    input wire logic       analog_output_pin,
    input wire logic       internal_use,
    input wire logic       conversion_busy
);
    int n_ff;
    always_ff @(posedge sys_clk) n_ff <= (rst || !conversion_busy) ? 0 : n_ff + 1;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_route; converter_enable |-> (analog_output_pin ^ internal_use); endproperty
    a_route: assert property (p_route) else $error("route wrong");
    property p_off; !converter_enable |-> !(analog_output_pin || internal_use); endproperty
    a_off: assert property (p_off) else $error("disabled but routed");
    property p_idle; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");
    property p_unmap; (reg_read && reg_addr == 2'h3) |=> reg_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_len; $fell(conversion_busy) |-> n_ff == CONV_COUNT; endproperty
    a_len: assert property (p_len) else $error("busy length");
    property p_max; conversion_busy |-> n_ff < CONV_COUNT; endproperty
    a_max: assert property (p_max) else $error("busy restarted");
    property p_en;
        (reg_write && reg_addr == 2'h0) |=> converter_enable == $past(reg_wdata[0]);
    endproperty
    a_en: assert property (p_en) else $error("enable bit");
    property p_low; (reg_write && reg_addr == 2'h1) |=> $stable(converter_value); endproperty
    a_low: assert property (p_low) else $error("low write updated");
    c_busy: cover property ($rose(conversion_busy));
    c_pin: cover property (analog_output_pin);
    c_unmap: cover property (reg_read && reg_addr == 2'h3);
endmodule
bind dac_input_update_control dac_update_chk #(.CONV_COUNT(CONV_COUNT)) dac_update_chk_i (.sys_clk,
    .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .converter_value,
    .converter_enable, .analog_output_pin, .internal_use, .conversion_busy);

// ===== test/dac_input_update_control_tb.sv
// Self-checking bench for the converter update control
`timescale 1ns/1ps
module dac_input_update_control_tb;
    import dac_update_pkg::*;
    logic       sys_clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00, event_flags = 8'h00, reg_rdata;
    logic [9:0] converter_value, prev;
    logic       converter_enable, analog_output_pin, internal_use, conversion_busy;
    int         failures = 0, checks = 0;
    // Rows: control, low, high, expected value, expected pin
    logic [34:0] rows [4] = '{{8'h03, 8'hA5, 8'h02, 10'h2A5, 1'b1}, {8'h07, 8'hC0, 8'h81, 10'h207,
        1'b1}, {8'h01, 8'h00, 8'hFF, 10'h300, 1'b0}, {8'h00, 8'h12, 8'h34, 10'h000, 1'b0}};
    dac_input_update_control #(.CONV_COUNT(4)) dac_input_update_control_i (.sys_clk, .rst,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .event_flags, .converter_value,
        .converter_enable, .analog_output_pin, .internal_use, .conversion_busy);
    initial forever #5 sys_clk = ~sys_clk;
    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk) {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge sys_clk) reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge sys_clk) {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge sys_clk) reg_read <= 1'b0;
        #1 chk(10'(reg_rdata), 10'(e));
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic conclude();
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        conclude();
    end
    initial begin
        tick(4);
        rst <= 1'b0;
        for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
        foreach (rows[i]) begin
            wr(OFS_CONTROL, rows[i][34:27]);
            wr(OFS_VALUE_LOW, rows[i][26:19]);
            wr(OFS_VALUE_HIGH, rows[i][18:11]);
            #1 chk(converter_value, rows[i][10:1]);
            chk(10'(analog_output_pin), 10'(rows[i][0]));
            chk(10'(internal_use), 10'(rows[i][27] & ~rows[i][28]));
        end
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'h00);
        wr(OFS_CONTROL, 8'h07);
        wr(OFS_VALUE_HIGH, 8'h81);
        wr(OFS_CONTROL, 8'h03);
        #1 chk(converter_value, 10'h204);
        wr(OFS_VALUE_LOW, 8'h5A);
        #1 chk(converter_value, 10'h204);
        wr(OFS_VALUE_HIGH, 8'h81);
        #1 chk(converter_value, 10'h15A);
        prev = 10'h15A;
        wr(OFS_VALUE_LOW, 8'h40);
        for (int s = 0; s < NUM_SOURCES; s++) begin
            wr(OFS_CONTROL, 8'h87 | 8'(s << 4));
            wr(OFS_VALUE_HIGH, 8'(8'h10 + s));
            event_flags <= 8'(1 << ((s + 1) % 8));
            tick(8);
            #1 chk(converter_value, prev);
            event_flags[s] <= 1'b1;
            tick(12);
            prev = {8'(8'h10 + s), 2'b01};
            #1 chk(converter_value, prev);
            chk(10'(conversion_busy), 10'h000);
            event_flags <= 8'h00;
        end
        rd(OFS_CONTROL, 8'hF7);
        wr(OFS_VALUE_LOW, 8'hC0);
        event_flags[7] <= 1'b1;
        tick(12);
        #1 chk(converter_value, prev);
        // A second trigger rise inside the conversion window must not restart it
        wr(OFS_VALUE_HIGH, 8'h55);
        event_flags[7] <= 1'b0;
        tick(4);
        event_flags[7] <= 1'b1;
        @(posedge sys_clk) event_flags[7] <= 1'b0;
        @(posedge sys_clk) event_flags[7] <= 1'b1;
        tick(4);
        #1 chk(10'(conversion_busy), 10'h001);
        chk(converter_value, 10'h157);
        tick(1);
        #1 chk(10'(conversion_busy), 10'h000);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        #1 chk(converter_value, 10'h000);
        // Selected flag high with auto-trigger off: enabled output shows the cleared shadow
        wr(OFS_CONTROL, 8'h71);
        tick(4);
        #1 chk(converter_value, 10'h000);
        chk(10'(conversion_busy), 10'h000);
        conclude();
    end
endmodule
